// *** hrs_map.svh ***
// Named constants for the hardware return stack.
// Included by the package and the design modules; definitions only.
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH

// Stack geometry
`define HRS_DEPTH 16
`define HRS_WIDTH 16

// Pointer value after any reset
`define HRS_PTR_RESET 'h0

// Flag level after any reset
`define HRS_FLAG_RESET 1'h1

`endif

// *** hrs_pkg.sv ***
// Types shared by the hardware return stack and its core-side user.
// Assumes hrs_map.svh is on the include path.
`include "hrs_map.svh"

package hrs_pkg;

   // Stack events requested by the instruction sequencer
   typedef struct packed {
      logic call_push;             // Subroutine call executes
      logic irq_push;              // Interrupt acknowledged, core vectors
      logic ret_pop;               // Plain return executes
      logic literal_pop;           // return_with_literal executes
      logic interrupt_pop;         // return_from_interrupt executes
   } hrs_req_type;

   // Availability tracking, one-hot codes
   typedef enum logic [2:0] {
      HRS_AVAIL  = 3'h1,
      HRS_AT_TOP = 3'h2,
      HRS_LOCKED = 3'h4
   } hrs_state_type;

endpackage : hrs_pkg

// *** hrs_mem.sv ***
// Storage array of the hardware return stack.
// Assumes one clock; write is clocked, read is combinational.
`timescale 1ns/1ns
`default_nettype none

`include "hrs_map.svh"

module hrs_mem #(
   parameter int WIDTH = `HRS_WIDTH,
   parameter int DEPTH = `HRS_DEPTH,
   parameter int PTR_W = $clog2(`HRS_DEPTH)
) (
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [PTR_W-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [PTR_W-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   // Entries hold no reset value; the pointer alone defines what is live
   logic [WIDTH-1:0] entry [DEPTH];

   // One write enable per entry, decoded from the write address
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_entry
         always_ff @(posedge sys_clk) begin
            if (wr_en && (wr_addr == PTR_W'(gi))) begin
               entry[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // Asynchronous read keeps the pop answer one cycle after the request
   assign rd_data = entry[rd_addr];

endmodule : hrs_mem

`default_nettype wire

// *** hrs_stack.sv ***
// Hardware return stack: sixteen program-counter words beside the core.
// Entries keep their contents over reset; pointer, pop_data, pop_valid and op_conflict clear, flag sets.
// Assumes the sequencer raises at most one push or one pop per cycle,
// all inputs synchronous to sys_clk, and rst held at least one edge.
`timescale 1ns/1ns
`default_nettype none

`include "hrs_map.svh"

// Operation
// - Sixteen 16-bit entries outside both memories
// - Pointer never visible to software
// - Push PC on call or interrupt acknowledge
// - Pop on the three return kinds only
// - High latch untouched by push or pop
// - Circular pointer, zero after every reset
// - Availability flag set after reset
// - Flag clear while pointer equals fifteen
// - Wrap fifteen to zero locks flag clear
// - Underflow shown only through the flag
// - Pop-first then push locks flag clear
// - Pushes beyond sixteen overwrite oldest entries
module hrs_stack #(
   parameter int WIDTH = `HRS_WIDTH,
   parameter int DEPTH = `HRS_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire hrs_pkg::hrs_req_type req,
   input wire logic [WIDTH-1:0] pc_in,
   output logic [WIDTH-1:0] pop_data,
   output logic pop_valid,
   output logic op_conflict,
   output logic stack_space_flag
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W-1:0] PTR_TOP = PTR_W'(DEPTH - 1);
   localparam logic [PTR_W-1:0] PTR_ZERO = PTR_W'(`HRS_PTR_RESET);

   // Refuse geometries that the wrapping pointer cannot serve
   if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
      $error("hrs_stack: DEPTH must be a power of two, at least 2");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("hrs_stack: WIDTH must be at least 1");
   end

   // Any request that stores the program counter
   function automatic logic is_push(input hrs_pkg::hrs_req_type r);
      is_push = r.call_push | r.irq_push;
   endfunction : is_push

   // Any request that returns a stored address
   function automatic logic is_pop(input hrs_pkg::hrs_req_type r);
      is_pop = r.ret_pop | r.literal_pop | r.interrupt_pop;
   endfunction : is_pop

   logic [PTR_W-1:0] ptr;
   logic [PTR_W-1:0] next_ptr;
   hrs_pkg::hrs_state_type state;
   hrs_pkg::hrs_state_type next_state;
   logic do_push;
   logic do_pop;
   logic clash;
   logic [PTR_W-1:0] rd_addr;
   logic [WIDTH-1:0] rd_data;
   logic [WIDTH-1:0] next_pop_data;
   logic next_pop_valid;
   logic next_op_conflict;

   // A push and a pop together are dropped: neither order is defined
   // op_conflict tells the sequencer that both requests were lost
   always_comb begin
      clash = is_push(req) && is_pop(req);
      do_push = is_push(req) && !clash;
      do_pop = is_pop(req) && !clash;
   end

   // Pop reads the entry just below the pointer
   // Read is combinational so the answer lands one edge after the pop
   assign rd_addr = ptr - 1'b1;

   // Storage lives outside any addressable space
   hrs_mem #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH),
      .PTR_W(PTR_W)
   ) u_mem (
      .sys_clk(sys_clk),
      .wr_en(do_push),
      .wr_addr(ptr),
      .wr_data(pc_in),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // Flag states: AVAIL while the pointer is below the top, AT_TOP while it
   // sits on the top entry without a wrap, LOCKED once a push has carried it
   // from the top back to zero. A pop from zero lands on the top as well, so
   // underflow and a full stack look alike to software; that is intended.
   // Pointer and availability, next values
   always_comb begin
      next_ptr = ptr;
      next_state = state;
      if (do_push) begin
         next_ptr = ptr + 1'b1;
      end else if (do_pop) begin
         next_ptr = ptr - 1'b1;
      end
      case (state)
         hrs_pkg::HRS_AVAIL: begin
            if (next_ptr == PTR_TOP) begin
               next_state = hrs_pkg::HRS_AT_TOP;
            end
         end
         hrs_pkg::HRS_AT_TOP: begin
            if (do_push) begin
               next_state = hrs_pkg::HRS_LOCKED;
            end else if (do_pop) begin
               next_state = hrs_pkg::HRS_AVAIL;
            end
         end
         hrs_pkg::HRS_LOCKED: begin
            next_state = hrs_pkg::HRS_LOCKED;
         end
         default: begin
            next_state = hrs_pkg::HRS_LOCKED;
         end
      endcase
   end

   // Pointer and availability, registered; only reset leaves the lock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ptr <= PTR_ZERO;
         state <= hrs_pkg::HRS_AVAIL;
      end else begin
         ptr <= next_ptr;
         state <= next_state;
      end
   end

   // Underflow has no flag of its own: wrapping to the top clears this
   assign stack_space_flag = (state == hrs_pkg::HRS_AVAIL);

   // Pop answer, next values; only the stack word, the high latch is not touched
   always_comb begin
      next_pop_data = pop_data;
      next_pop_valid = do_pop;
      next_op_conflict = clash;
      if (do_pop) begin
         next_pop_data = rd_data;
      end
   end

   // Pop answer, registered
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pop_data <= '0;
         pop_valid <= 1'h0;
         op_conflict <= 1'h0;
      end else begin
         pop_data <= next_pop_data;
         pop_valid <= next_pop_valid;
         op_conflict <= next_op_conflict;
      end
   end

   // Checks of the stack behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // Helper: first request after reset was a pop, and no request since;
   // any later request ends the window in which a push must lock the flag
   logic seen_op;
   logic pop_first;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         seen_op <= 1'h0;
         pop_first <= 1'h0;
      end else if (!seen_op && (do_push || do_pop)) begin
         seen_op <= 1'h1;
         pop_first <= do_pop;
      end else if (do_push || do_pop) begin
         pop_first <= 1'h0;
      end
   end

   a_reset_state: assert property (disable iff (1'b0)
      rst |=> (ptr == PTR_ZERO) && stack_space_flag && !pop_valid)
      else $error("reset did not clear pointer and set flag");

   a_push_step: assert property (
      do_push |=> ptr == $past(ptr) + 1'b1)
      else $error("push did not advance pointer by one");

   a_pop_step: assert property (
      do_pop |=> (ptr == $past(ptr) - 1'b1) && pop_valid)
      else $error("pop did not retreat pointer or answer");

   a_idle_hold: assert property (
      !do_push && !do_pop |=> $stable(ptr) && !pop_valid)
      else $error("pointer moved without a request");

   a_top_clear: assert property (
      ptr == PTR_TOP |-> !stack_space_flag)
      else $error("flag set while pointer at top");

   a_wrap_lock: assert property (
      do_push && ptr == PTR_TOP |=> !stack_space_flag [*8])
      else $error("flag returned after wrap");

   a_pop_first: assert property (
      !seen_op && do_pop |=> !stack_space_flag)
      else $error("pop before any push left flag set");

   a_pop_push_lock: assert property (
      pop_first && do_push |=> !stack_space_flag [*8])
      else $error("push after first pop did not lock flag");

   a_push_return: assert property (
      do_push ##1 (do_pop && !do_push) |=> pop_data == $past(pc_in, 2))
      else $error("pop did not return the last pushed word");

   a_overwrite_order: assert property (
      (do_push && ptr == PTR_ZERO) ##1 (!do_pop && !do_push) [*1] |-> u_mem.entry[0] == $past(pc_in, 1))
      else $error("push did not land in pointer slot");

   a_conflict_drop: assert property (
      clash |=> $stable(ptr) && op_conflict && !pop_valid)
      else $error("simultaneous push and pop not dropped");

   // Sticky record of a wrap from the top; the check below then covers
   // the rest of the run and not only a fixed window of cycles
   logic wrapped;
   logic next_wrapped;
   always_comb begin
      next_wrapped = wrapped | (do_push && ptr == PTR_TOP);
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wrapped <= 1'h0;
      end else begin
         wrapped <= next_wrapped;
      end
   end

   // Flag lock, flag return and the answer to each kind of request
   a_lock_sticky: assert property (
      wrapped |-> !stack_space_flag)
      else $error("flag set again after a wrap");

   a_locked_pop: assert property (
      state == hrs_pkg::HRS_LOCKED && do_pop |=> !stack_space_flag)
      else $error("pop released a locked flag");

   a_top_return: assert property (
      state == hrs_pkg::HRS_AT_TOP && do_pop |=> stack_space_flag)
      else $error("pop from unlocked top left flag clear");

   a_avail_below_top: assert property (
      state == hrs_pkg::HRS_AVAIL |-> ptr != PTR_TOP)
      else $error("flag state available with pointer at top");

   a_pop_under: assert property (
      do_pop && ptr == PTR_ZERO && !wrapped |=> ptr == PTR_TOP && !stack_space_flag)
      else $error("underflow did not wrap to top and clear flag");

   a_push_no_answer: assert property (
      do_push |=> !pop_valid)
      else $error("push produced a pop answer");

   a_pop_data_hold: assert property (
      !do_pop |=> $stable(pop_data))
      else $error("returned word changed without a pop");

   a_conflict_quiet: assert property (
      !clash |=> !op_conflict)
      else $error("conflict reported without a clash");

   a_clash_state: assert property (
      clash |=> $stable(state))
      else $error("dropped request moved the flag state");

   a_pop_clean: assert property (
      pop_valid |-> !op_conflict)
      else $error("pop answer and conflict together");

   // Per-entry check: the slot under the pointer takes the pushed word
   for (genvar ci = 0; ci < DEPTH; ci++) begin : g_entry_chk
      a_slot_write: assert property (
         do_push && ptr == PTR_W'(ci) |=> u_mem.entry[ci] == $past(pc_in))
         else $error("push did not land in its slot");
   end

endmodule : hrs_stack

`default_nettype wire

// *** hrs_core_model.sv ***
// Core-side model: program counter reloaded from returned words.
// Assumes hrs_stack answers each pop with a one-cycle pop_valid.
`timescale 1ns/1ns
`default_nettype none

module hrs_core_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic pop_valid,
   input wire logic [15:0] pop_data,
   output logic [15:0] pc
);
   logic [15:0] next_pc;

   // Whole word reloads the counter; high latch is kept elsewhere
   always_comb begin
      next_pc = pop_valid ? pop_data : pc;
   end

   // Counter register, cleared on reset
   always_ff @(posedge sys_clk) begin
      pc <= rst ? 16'h0000 : next_pc;
   end
endmodule : hrs_core_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for hrs_stack with a core-side model.
// Assumes one 250 MHz clock and synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   hrs_pkg::hrs_req_type req = '0;
   logic [15:0] pc_in = 16'h0000;
   logic [15:0] pop_data;
   logic [15:0] core_pc;
   logic pop_valid;
   logic op_conflict;
   logic stack_space_flag;
   logic [4:0] kinds [3] = '{5'h04, 5'h02, 5'h01};
   int err_total = 0;
   int comparisons = 0;

   // Clock, 4 ns period
   always #2 sys_clk = ~sys_clk;

   hrs_stack hrs_stack_inst (.sys_clk(sys_clk), .rst(rst), .req(req), .pc_in(pc_in), .pop_data(pop_data),
      .pop_valid(pop_valid), .op_conflict(op_conflict), .stack_space_flag(stack_space_flag));
   hrs_core_model hrs_core_model_inst (.sys_clk(sys_clk), .rst(rst), .pop_valid(pop_valid),
      .pop_data(pop_data), .pc(core_pc));

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task fl(input logic e);
      chk("flag", {15'h0, e}, {15'h0, stack_space_flag});
   endtask : fl

   // One request pulse; returns just after the edge that took it
   task step(input logic [4:0] r, input logic [15:0] p);
      @(posedge sys_clk);
      req <= hrs_pkg::hrs_req_type'(r);
      pc_in <= p;
      @(posedge sys_clk);
      req <= '0;
      #1;
   endtask : step

   task pop(input logic [4:0] r, input logic [15:0] exp);
      step(r, 16'h0000);
      chk("pop_valid", 16'h0001, {15'h0, pop_valid});
      chk("op_conflict", 16'h0000, {15'h0, op_conflict});
      chk("pop_data", exp, pop_data);
      @(posedge sys_clk);
      #1;
      chk("core_pc", exp, core_pc);
      chk("pop_valid", 16'h0000, {15'h0, pop_valid});
   endtask : pop

   task do_reset;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      fl(1'b1);
      chk("pop_valid", 16'h0000, {15'h0, pop_valid});
   endtask : do_reset

   task fill_and_unwind;
      for (int i = 0; i < 15; i++) begin
         step(i[0] ? 5'h08 : 5'h10, 16'ha000 + 16'(i));
         fl(i != 14);
      end
      for (int i = 14; i >= 0; i--) begin
         pop(kinds[i % 3], 16'ha000 + 16'(i));
         fl(1'b1);
      end
   endtask : fill_and_unwind

   // Mixed push and pop is dropped, pointer kept
   task conflict;
      step(5'h10, 16'h1234);
      step(5'h14, 16'hbeef);
      chk("op_conflict", 16'h0001, {15'h0, op_conflict});
      pop(5'h04, 16'h1234);
   endtask : conflict

   // Push and pop on adjacent edges; the pop returns that push
   task back_to_back;
      @(posedge sys_clk);
      req <= hrs_pkg::hrs_req_type'(5'h08);
      pc_in <= 16'h5a5a;
      @(posedge sys_clk);
      req <= hrs_pkg::hrs_req_type'(5'h02);
      pc_in <= 16'h0000;
      @(posedge sys_clk);
      req <= '0;
      #1;
      chk("pop_valid", 16'h0001, {15'h0, pop_valid});
      chk("pop_data", 16'h5a5a, pop_data);
      fl(1'b1);
   endtask : back_to_back

   task overflow;
      for (int i = 0; i < 17; i++) step(5'h10, 16'hc000 + 16'(i));
      fl(1'b0);
      pop(5'h04, 16'hc010);
      pop(5'h02, 16'hc00f);
      pop(5'h01, 16'hc00e);
      fl(1'b0);
   endtask : overflow

   // Entries survive reset, so the wrapped pop sees the old top
   task underflow;
      do_reset();
      pop(5'h01, 16'hc00f);
      fl(1'b0);
      step(5'h08, 16'hd000);
      pop(5'h04, 16'hd000);
      pop(5'h04, 16'hc00e);
      fl(1'b0);
      do_reset();
   endtask : underflow

   task close_out;
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      do_reset();
      fill_and_unwind();
      conflict();
      back_to_back();
      overflow();
      underflow();
      close_out();
   end

   // Watchdog, well past the expected run of under two hundred cycles
   initial begin
      #20000;
      err_total++;
      close_out();
   end
endmodule : tb
`default_nettype wire
